/* File: pfbm_pkg.sv */
// Package with pin bundles, timing constants and command encodings for the flash host.
package pfbm_pkg;

    localparam int unsigned CLK_PERIOD_PS = 5000;

    // Device timing in ns, as used by this host
    localparam int unsigned T_ACC_NS     = 70;
    localparam int unsigned T_WRITE_NS   = 35;
    localparam int unsigned T_WHIGH_NS   = 20;
    localparam int unsigned T_RP_NS      = 500;
    localparam int unsigned T_RH_NS      = 50;
    localparam int unsigned T_RDY_NS     = 20000;

    function automatic int unsigned ns_up(input int unsigned ns);
        ns_up = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (ns_up == 0) ns_up = 1;
    endfunction : ns_up

    localparam int unsigned CYC_ACC   = ns_up(T_ACC_NS);
    localparam int unsigned CYC_WRITE = ns_up(T_WRITE_NS);
    localparam int unsigned CYC_WHIGH = ns_up(T_WHIGH_NS);
    localparam int unsigned CYC_RP    = ns_up(T_RP_NS);
    localparam int unsigned CYC_RH    = ns_up(T_RH_NS);
    localparam int unsigned CYC_RDY   = ns_up(T_RDY_NS);

    localparam int unsigned CNT_W   = 13;
    localparam int unsigned ADDR_W  = 20;
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned SECT_W  = 6;
    localparam int unsigned SEQ_MAX = 6;

    localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;

    // Sector decode fields
    localparam int unsigned SA_HI   = 19;
    localparam int unsigned SA_LO   = 12;
    localparam logic [4:0] TOP_REGION = 5'h1f;
    localparam logic [5:0] SECT_TOP   = 6'h1f;

    // Host request kinds
    typedef enum logic [2:0] {
        PFBM_OP_READ    = 3'h0,
        PFBM_OP_WRITE   = 3'h1,
        PFBM_OP_PROGRAM = 3'h2,
        PFBM_OP_FASTPRG = 3'h3,
        PFBM_OP_ERASE   = 3'h4,
        PFBM_OP_CHIPERS = 3'h5,
        PFBM_OP_RESET   = 3'h6
    } pfbm_op_t;

    typedef struct packed {
        pfbm_op_t              op;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     data;
    } pfbm_req_t;

    // One bus cycle of a command sequence
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } pfbm_cyc_t;

    // Pins driven toward the flash
    typedef struct packed {
        logic                  chip_select_n;
        logic                  output_gate_n;
        logic                  write_strobe_n;
        logic                  hard_reset_line;
        logic                  width_select_n;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     dq_out;
        logic                  dq_oe;
    } pfbm_pins_t;

    // Generic unlock and command codes; parameters of the sequencer
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 20'h0_0555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 20'h0_02aa;
    localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00aa;
    localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_PROG  = 16'h00a0;
    localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0080;
    localparam logic [DATA_W-1:0] CMD_SECT  = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_CHIP  = 16'h0010;

endpackage : pfbm_pkg

/* File: pfbm_seq_rom.sv */
`timescale 1ns/1ps
// Command sequence table: bus cycle for a given request and step, registered.
module pfbm_seq_rom
    import pfbm_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    // Lookup
    input  wire pfbm_pkg::pfbm_op_t op_i,
    input  wire logic [2:0]        step_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    // Result
    output pfbm_pkg::pfbm_cyc_t    cyc_o,
    output logic [2:0]             len_o
);
    import pfbm_pkg::*;

    pfbm_cyc_t  cyc_nxt;
    logic [2:0] len_nxt;

    always_comb begin
        cyc_nxt = '{addr: addr_i, data: data_i};
        len_nxt = 3'h1;
        case (op_i)
            PFBM_OP_PROGRAM: begin
                len_nxt = 3'h4;
                case (step_i)
                    3'h0:    cyc_nxt = '{addr: UNLOCK_A1, data: UNLOCK_D1};
                    3'h1:    cyc_nxt = '{addr: UNLOCK_A2, data: UNLOCK_D2};
                    3'h2:    cyc_nxt = '{addr: UNLOCK_A1, data: CMD_PROG};
                    default: cyc_nxt = '{addr: addr_i, data: data_i};
                endcase
            end
            PFBM_OP_FASTPRG: begin
                len_nxt = 3'h2;
                if (step_i == 3'h0) cyc_nxt = '{addr: UNLOCK_A1, data: CMD_PROG};
            end
            PFBM_OP_ERASE, PFBM_OP_CHIPERS: begin
                len_nxt = 3'h6;
                case (step_i)
                    3'h0, 3'h3: cyc_nxt = '{addr: UNLOCK_A1, data: UNLOCK_D1};
                    3'h1, 3'h4: cyc_nxt = '{addr: UNLOCK_A2, data: UNLOCK_D2};
                    3'h2:       cyc_nxt = '{addr: UNLOCK_A1, data: CMD_ERASE};
                    default: begin
                        if (op_i == PFBM_OP_CHIPERS)
                            cyc_nxt = '{addr: UNLOCK_A1, data: CMD_CHIP};
                        else
                            cyc_nxt = '{addr: addr_i, data: CMD_SECT};
                    end
                endcase
            end
            default: begin
                len_nxt = 3'h1;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            cyc_o <= '0;
            len_o <= 3'h1;
        end else begin
            cyc_o <= cyc_nxt;
            len_o <= len_nxt;
        end
    end

endmodule : pfbm_seq_rom

/* File: pfbm_host.sv */
`timescale 1ns/1ps
// Host-side bus controller for a boot-sector parallel NOR flash.

// How it works
// - Command cycles drive write strobe and chip select low, output gate high.
// - Fast program mode issues two write cycles instead of four.
// - Host pulses reissue_o when a reset request interrupts a program or erase.
// - Host asserts chip select only after reset line is high.
// - Idle reset finishes within recovery time; read after reset-high time.
module pfbm_host
    import pfbm_pkg::*;
(
    // Clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 reset_n_i,
    // User request
    input  wire logic                 req_valid_i,
    input  wire pfbm_pkg::pfbm_req_t  req_i,
    input  wire logic                 byte_mode_i,
    output logic                      req_ready_o,
    // User answer
    output logic                      rsp_valid_o,
    output logic [DATA_W-1:0]         rsp_data_o,
    output logic [SECT_W-1:0]         rsp_sector_o,
    output logic                      busy_o,
    output logic                      reissue_o,
    // Flash pins
    output pfbm_pkg::pfbm_pins_t      pins_o,
    input  wire logic [DATA_W-1:0]    dq_i,
    input  wire logic                 ready_busy_line_i
);
    import pfbm_pkg::*;

    typedef enum logic [6:0] {
        ST_RST   = 7'b000_0001,
        ST_RHOLD = 7'b000_0010,
        ST_IDLE  = 7'b000_0100,
        ST_WLOW  = 7'b000_1000,
        ST_WHIGH = 7'b001_0000,
        ST_READ  = 7'b010_0000,
        ST_RWAIT = 7'b100_0000
    } pfbm_state_t;

    // Top-boot sector index from address bits 19..12
    function automatic logic [SECT_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
        logic [7:0] s;
        s = a[SA_HI:SA_LO];
        if (s[7:3] != TOP_REGION) sector_of = SECT_W'(s[7:3]);
        else if (!s[2])           sector_of = SECT_TOP;
        else if (s[1])            sector_of = SECT_TOP + 6'h03;
        else                      sector_of = SECT_TOP + 6'h01 + SECT_W'(s[0]);
    endfunction : sector_of

    pfbm_state_t       state_r;
    logic [CNT_W-1:0]  cnt_r;
    logic [2:0]        step_r;
    pfbm_req_t         req_r;
    logic              width_n_r;
    logic              inflight_r;
    logic [DATA_W-1:0] dq_s1_r;
    logic [DATA_W-1:0] dq_s2_r;
    logic              rb_s1_r;
    logic              rb_s2_r;
    logic              rb_s3_r;
    pfbm_cyc_t         rom_cyc;
    logic [2:0]        rom_len;
    logic              cnt_done;

    assign cnt_done = (cnt_r == CNT_ONE);

    pfbm_seq_rom u_rom (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .op_i      (req_r.op),
        .step_i    (step_r),
        .addr_i    (req_r.addr),
        .data_i    (req_r.data),
        .cyc_o     (rom_cyc),
        .len_o     (rom_len)
    );

    // Pin inputs come from another timing world
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            dq_s1_r <= '0;
            dq_s2_r <= '0;
            rb_s1_r <= 1'b0;
            rb_s2_r <= 1'b0;
            rb_s3_r <= 1'b0;
        end else begin
            dq_s1_r <= dq_i;
            dq_s2_r <= dq_s1_r;
            rb_s1_r <= ready_busy_line_i;
            rb_s2_r <= rb_s1_r;
            rb_s3_r <= rb_s2_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_r <= ST_RST;
            cnt_r   <= CNT_W'(CYC_RP);
            step_r  <= 3'h0;
            req_r   <= '0;
        end else begin
            case (state_r)
                ST_RST: begin
                    // Hold reset low for its pulse time
                    if (cnt_done) begin
                        state_r <= ST_RHOLD;
                        cnt_r   <= CNT_W'(CYC_RDY);
                    end else cnt_r <= cnt_r - CNT_ONE;
                end
                ST_RHOLD: begin
                    // Wait for ready line or worst-case recovery, then reset-high time
                    if (cnt_r > CNT_W'(CYC_RH) && !rb_s2_r)
                        cnt_r <= cnt_r - CNT_ONE;
                    else if (cnt_r > CNT_W'(CYC_RH))
                        cnt_r <= CNT_W'(CYC_RH);
                    else if (cnt_done) state_r <= ST_IDLE;
                    else cnt_r <= cnt_r - CNT_ONE;
                end
                ST_IDLE: begin
                    step_r <= 3'h0;
                    if (req_valid_i) begin
                        req_r <= req_i;
                        if (req_i.op == PFBM_OP_RESET) begin
                            state_r <= ST_RST;
                            cnt_r   <= CNT_W'(CYC_RP);
                        end else if (req_i.op == PFBM_OP_READ) begin
                            state_r <= ST_READ;
                            cnt_r   <= CNT_W'(CYC_ACC);
                        end else begin
                            state_r <= ST_WHIGH;
                            cnt_r   <= CNT_ONE;
                        end
                    end
                end
                ST_WHIGH: begin
                    // One extra edge lets the table register the cycle
                    if (cnt_done) begin
                        state_r <= ST_WLOW;
                        cnt_r   <= CNT_W'(CYC_WRITE);
                    end else cnt_r <= cnt_r - CNT_ONE;
                end
                ST_WLOW: begin
                    if (cnt_done) begin
                        step_r <= step_r + 3'h1;
                        if (step_r + 3'h1 >= rom_len) state_r <= ST_IDLE;
                        else begin
                            state_r <= ST_WHIGH;
                            cnt_r   <= CNT_W'(CYC_WHIGH);
                        end
                    end else cnt_r <= cnt_r - CNT_ONE;
                end
                ST_READ: begin
                    // Sample after access time; sleep or standby exit both fit
                    if (cnt_done) state_r <= ST_RWAIT;
                    else cnt_r <= cnt_r - CNT_ONE;
                end
                ST_RWAIT: begin
                    // Two synchroniser edges before data is trusted
                    if (cnt_r == CNT_W'(3)) state_r <= ST_IDLE;
                    else cnt_r <= cnt_r + CNT_ONE;
                end
                default: state_r <= ST_RST;
            endcase
        end
    end

    // Width select latched with each request
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) width_n_r <= 1'b1;
        else if (state_r == ST_IDLE && req_valid_i) width_n_r <= !byte_mode_i;
    end

    // Track a program or erase the device may still be running
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            inflight_r <= 1'b0;
            reissue_o  <= 1'b0;
        end else begin
            reissue_o <= 1'b0;
            if (state_r == ST_WLOW && cnt_done && step_r + 3'h1 >= rom_len
                && req_r.op != PFBM_OP_WRITE)
                inflight_r <= 1'b1;
            // Clear on the ready rise; the line drops only after the last strobe
            else if (rb_s2_r && !rb_s3_r)
                inflight_r <= 1'b0;
            if (state_r == ST_IDLE && req_valid_i && req_i.op == PFBM_OP_RESET
                && inflight_r) begin
                reissue_o  <= 1'b1;
                inflight_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rsp_valid_o  <= 1'b0;
            rsp_data_o   <= '0;
            rsp_sector_o <= '0;
        end else begin
            rsp_valid_o <= (state_r == ST_RWAIT && cnt_r == CNT_W'(3))
                        || (state_r == ST_WLOW && cnt_done && step_r + 3'h1 >= rom_len);
            if (state_r == ST_RWAIT && cnt_r == CNT_W'(3))
                rsp_data_o <= width_n_r ? dq_s2_r : {8'h00, dq_s2_r[7:0]};
            if (state_r == ST_IDLE && req_valid_i)
                rsp_sector_o <= sector_of(req_i.addr);
        end
    end

    // Pin drive
    always_comb begin
        pins_o                 = '0;
        pins_o.hard_reset_line = !(state_r == ST_RST);
        pins_o.chip_select_n   = !(state_r == ST_WLOW || state_r == ST_READ
                               || state_r == ST_RWAIT);
        pins_o.output_gate_n   = !(state_r == ST_READ || state_r == ST_RWAIT);
        pins_o.write_strobe_n  = !(state_r == ST_WLOW);
        pins_o.width_select_n  = width_n_r;
        pins_o.addr            = (state_r == ST_WLOW) ? rom_cyc.addr : req_r.addr;
        pins_o.dq_out          = (state_r == ST_WLOW) ? rom_cyc.data : '0;
        if (!width_n_r) pins_o.dq_out[15] = req_r.data[15] & (state_r == ST_READ);
        pins_o.dq_oe           = (state_r == ST_WLOW) || !width_n_r;
    end

    assign req_ready_o = (state_r == ST_IDLE);
    assign busy_o      = inflight_r && !rb_s2_r;

endmodule : pfbm_host

/* File: pfbm_host_assertions.sv */
// Concurrent checks on the flash host pins and the strobe count of each program and erase request.
`timescale 1ns/1ps
module pfbm_host_assertions
    import pfbm_pkg::*;
(
    // Clock and reset
    input wire logic                 mclk_i,
    input wire logic                 reset_n_i,
    // User side
    input wire logic                 req_valid_i,
    input wire pfbm_pkg::pfbm_req_t  req_i,
    input wire logic                 byte_mode_i,
    input wire logic                 req_ready_o,
    input wire logic                 rsp_valid_o,
    // Flash pins
    input wire pfbm_pkg::pfbm_pins_t pins_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    int       rp_cnt = 0;
    int       rh_cnt = 0;
    int       wcnt   = 0;
    logic     byte_r = 1'b0;
    logic     we_q   = 1'b1;
    pfbm_op_t op_r   = PFBM_OP_READ;
    // Counters let one check span hundreds of cycles
    always_ff @(posedge mclk_i) begin
        rp_cnt <= pins_o.hard_reset_line ? 0 : rp_cnt + 1;
        rh_cnt <= pins_o.hard_reset_line ? rh_cnt + 1 : 0;
        we_q <= pins_o.write_strobe_n;
        if (req_valid_i && req_ready_o) begin
            op_r <= req_i.op;
            byte_r <= byte_mode_i;
            wcnt <= 0;
        end else if (we_q && !pins_o.write_strobe_n) begin
            wcnt <= wcnt + 1;
        end
    end
    sequence s_read_hold;
        (!pins_o.output_gate_n && $stable(pins_o.addr))[*8];
    endsequence
    property p_cmd_levels;
        !pins_o.write_strobe_n |-> !pins_o.chip_select_n && pins_o.output_gate_n;
    endproperty
    a_cmd_levels: assert property (p_cmd_levels) else $error("bad write levels");
    property p_cs_after_rst;
        !pins_o.chip_select_n |-> pins_o.hard_reset_line;
    endproperty
    a_cs_after_rst: assert property (p_cs_after_rst) else $error("select in reset");
    property p_rst_pulse;
        $rose(pins_o.hard_reset_line) |-> rp_cnt >= CYC_RP;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short");
    property p_read_rh;
        $fell(pins_o.output_gate_n) |-> rh_cnt >= CYC_RH;
    endproperty
    a_read_rh: assert property (p_read_rh) else $error("read too soon");
    property p_read_hold;
        $fell(pins_o.output_gate_n) |=> s_read_hold;
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read cut short");
    property p_fast_two;
        rsp_valid_o && op_r == PFBM_OP_FASTPRG |-> wcnt == 2;
    endproperty
    a_fast_two: assert property (p_fast_two) else $error("fast program count");
    property p_std_four;
        rsp_valid_o && op_r == PFBM_OP_PROGRAM |-> wcnt == 4;
    endproperty
    a_std_four: assert property (p_std_four) else $error("program count");
    property p_erase_six;
        rsp_valid_o && (op_r == PFBM_OP_ERASE || op_r == PFBM_OP_CHIPERS) |-> wcnt == 6;
    endproperty
    a_erase_six: assert property (p_erase_six) else $error("erase count");
    property p_width;
        !pins_o.chip_select_n |-> pins_o.width_select_n == !byte_r;
    endproperty
    a_width: assert property (p_width) else $error("width select");
    property p_wr_hold;
        !pins_o.write_strobe_n && !$past(pins_o.write_strobe_n)
            |-> $stable(pins_o.addr) && $stable(pins_o.dq_out) && pins_o.dq_oe;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write not held");
endmodule : pfbm_host_assertions

bind pfbm_host pfbm_host_assertions pfbm_host_assertions_i (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .byte_mode_i(byte_mode_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .pins_o(pins_o));

/* File: pfbm_flash_model.sv */
// Behavioural flash device driven from the host pins.
`timescale 1ns/1ps
module pfbm_flash_model
    import pfbm_pkg::*;
#(
    parameter int         ACC_C   = 10,
    parameter int         RP_C    = 20,
    parameter int         PROG_C  = 300,
    parameter int         ERASE_C = 600,
    parameter int         RECOV_C = 200,
    parameter logic [7:0] ID_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] STAT    = 8'h48
)(
    input  wire logic                 mclk_i,
    input  wire pfbm_pkg::pfbm_pins_t pins_i,
    output logic [DATA_W-1:0]         dq_o,
    output logic                      ready_busy_line_o
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] prev_r = 16'h0000;
    logic [DATA_W-1:0] d_cap  = 16'h0000;
    logic [DATA_W-1:0] word;
    logic [DATA_W-1:0] val;
    logic [ADDR_W-1:0] a_cap  = 20'h0_0000;
    logic [ADDR_W-1:0] addr_r = 20'h0_0000;
    logic              wr_r   = 1'b0;
    logic              id_r   = 1'b0;
    int                acc_r  = 0;
    int                busy_r = 0;
    int                rp_r   = 0;
    wire logic wr_act = !pins_i.chip_select_n && !pins_i.write_strobe_n
                        && pins_i.output_gate_n && pins_i.hard_reset_line;
    // Released lines toggle so a stale value never passes for data
    wire logic rd_act = !pins_i.chip_select_n && !pins_i.output_gate_n
                        && pins_i.hard_reset_line && acc_r >= ACC_C;
    assign ready_busy_line_o = (busy_r == 0);
    initial dq_o = 16'h0000;
    always_comb begin
        word = mem.exists(pins_i.addr) ? mem[pins_i.addr] : pins_i.addr[15:0] ^ 16'ha5c3;
        if (busy_r != 0) word = {8'h00, STAT};
        else if (id_r) word = {8'h00, ID_CODE};
        val = pins_i.width_select_n ? word
            : {~dq_o[15:8], pins_i.dq_out[15] ? word[15:8] : word[7:0]};
    end
    always @(posedge mclk_i) begin
        dq_o <= rd_act ? val : ~dq_o;
        wr_r <= wr_act;
        addr_r <= pins_i.addr;
        acc_r <= (pins_i.chip_select_n || pins_i.addr != addr_r) ? 0 : acc_r + 1;
        if (busy_r != 0) busy_r <= busy_r - 1;
        if (wr_act) begin
            a_cap <= pins_i.addr;
            d_cap <= pins_i.dq_out;
        end
        if (!pins_i.hard_reset_line) begin
            rp_r <= rp_r + 1;
            if (rp_r == RP_C) begin
                id_r <= 1'b0;
                prev_r <= 16'h0000;
                busy_r <= (busy_r != 0) ? RECOV_C : 0;
            end
        end else begin
            rp_r <= 0;
            if (wr_r && !wr_act) begin
                prev_r <= d_cap;
                if (prev_r == CMD_PROG) begin
                    mem[a_cap] = d_cap;
                    busy_r <= PROG_C;
                end else if (d_cap == CMD_SECT || d_cap == CMD_CHIP) busy_r <= ERASE_C;
                else if (d_cap == 16'h0090) id_r <= 1'b1;
                else if (d_cap == 16'h00f0) id_r <= 1'b0;
            end
        end
    end
endmodule : pfbm_flash_model

/* File: pfbm_host_tb.sv */
// Self-checking bench for the flash host against the behavioural flash.
`timescale 1ns/1ps
module pfbm_host_tb;
    import pfbm_pkg::*;
    localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary value
    localparam logic [7:0] STAT    = 8'h48;
    logic              mclk_i      = 1'b0;
    logic              reset_n_i   = 1'b0;
    logic              req_valid_i = 1'b0;
    logic              byte_mode_i = 1'b0;
    pfbm_req_t         req_i       = '0;
    logic              req_ready_o, rsp_valid_o, busy_o, reissue_o, rbl;
    logic [DATA_W-1:0] rsp_data_o, dev_dq, got_d;
    logic [SECT_W-1:0] rsp_sector_o, got_s;
    pfbm_pins_t        pins_o;
    wire logic [DATA_W-1:0] dq_i;
    int   err_count = 0, checks_done = 0, rsp_n = 0, wfall = 0, reis = 0;
    logic we_q = 1'b1;
    // Pin 15 is host driven in byte reads, the rest during writes and, in byte mode, outside reads
    assign dq_i = {pins_o.dq_oe ? pins_o.dq_out[15] : dev_dq[15],
                   (pins_o.dq_oe && pins_o.output_gate_n) ? pins_o.dq_out[14:0] : dev_dq[14:0]};
    always #2.5 mclk_i = ~mclk_i;
    pfbm_host pfbm_host_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .byte_mode_i(byte_mode_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_sector_o(rsp_sector_o),
        .busy_o(busy_o), .reissue_o(reissue_o), .pins_o(pins_o), .dq_i(dq_i),
        .ready_busy_line_i(rbl));
    pfbm_flash_model #(.ID_CODE(ID_CODE), .STAT(STAT)) pfbm_flash_model_i (.mclk_i(mclk_i),
        .pins_i(pins_o), .dq_o(dev_dq), .ready_busy_line_o(rbl));
    always @(negedge mclk_i) begin
        we_q <= pins_o.write_strobe_n;
        if (we_q === 1'b1 && pins_o.write_strobe_n === 1'b0) wfall <= wfall + 1;
        if (reissue_o === 1'b1) reis <= reis + 1;
        if (rsp_valid_o === 1'b1) begin
            got_d <= rsp_data_o;
            got_s <= rsp_sector_o;
            rsp_n <= rsp_n + 1;
        end
    end
    function automatic logic [15:0] pat(input logic [19:0] a);
        return a[15:0] ^ 16'ha5c3;
    endfunction : pat
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_flag(ref logic f, input logic v, input int lim);
        int k;
        k = 0;
        @(negedge mclk_i);
        while (f !== v && k < lim) begin
            @(negedge mclk_i);
            k++;
        end
    endtask : wait_flag
    task automatic issue(input pfbm_op_t op, input logic [19:0] a, input logic [15:0] d,
                         input logic bm);
        int n, k;
        n = rsp_n;
        k = 0;
        wait_flag(req_ready_o, 1'b1, 6000);
        check("ready", {15'h0000, req_ready_o}, 16'h0001);
        @(posedge mclk_i);
        req_valid_i <= 1'b1;
        req_i <= '{op: op, addr: a, data: d};
        byte_mode_i <= bm;
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        while (op != PFBM_OP_RESET && rsp_n == n && k < 9000) begin
            @(negedge mclk_i);
            k++;
        end
        if (k >= 9000) check("answer", 16'h0000, 16'h0001);
    endtask : issue
    task automatic t_sectors();
        logic [25:0] tbl [12];
        tbl = '{{20'h0_0000, 6'h00}, {20'h0_7fff, 6'h00}, {20'h0_8000, 6'h01},
                {20'h7_ffff, 6'h0f}, {20'h8_0000, 6'h10}, {20'hf_7fff, 6'h1e},
                {20'hf_8000, 6'h1f}, {20'hf_bfff, 6'h1f}, {20'hf_c000, 6'h20},
                {20'hf_d000, 6'h21}, {20'hf_e000, 6'h22}, {20'hf_ffff, 6'h22}};
        foreach (tbl[i]) begin
            issue(PFBM_OP_READ, tbl[i][25:6], 16'h0000, 1'b0);
            check("read", got_d, pat(tbl[i][25:6]));
            check("sector", {10'h000, got_s}, {10'h000, tbl[i][5:0]});
        end
    endtask : t_sectors
    task automatic t_byte();
        logic [15:0] w;
        w = pat(20'h1_2345);
        for (int h = 0; h < 2; h++) begin
            issue(PFBM_OP_READ, 20'h1_2345, {h[0], 15'h0000}, 1'b1);
            check("byte", got_d, {8'h00, h[0] ? w[15:8] : w[7:0]});
        end
    endtask : t_byte
    task automatic t_prog(input pfbm_op_t op, input logic [19:0] a, input logic [15:0] d,
                          input int n);
        int w0;
        w0 = wfall;
        issue(op, a, d, 1'b0);
        check("strobes", 16'(wfall - w0), 16'(n));
        wait_flag(busy_o, 1'b1, 20);
        check("busy", {15'h0000, busy_o}, 16'h0001);
        issue(PFBM_OP_READ, a, 16'h0000, 1'b0);
        check("status", got_d, {8'h00, STAT});
        wait_flag(busy_o, 1'b0, 2000);
        check("done", {15'h0000, busy_o}, 16'h0000);
        if (n < 6) begin
            issue(PFBM_OP_READ, a, 16'h0000, 1'b0);
            check("readback", got_d, d);
        end
    endtask : t_prog
    task automatic t_ident();
        int w0;
        w0 = wfall;
        issue(PFBM_OP_WRITE, UNLOCK_A1, UNLOCK_D1, 1'b0);
        issue(PFBM_OP_WRITE, UNLOCK_A2, UNLOCK_D2, 1'b0);
        issue(PFBM_OP_WRITE, UNLOCK_A1, 16'h0090, 1'b0);
        check("writes", 16'(wfall - w0), 16'h0003);
        issue(PFBM_OP_READ, 20'h0_0000, 16'h0000, 1'b0);
        check("ident", got_d, {8'h00, ID_CODE});
        issue(PFBM_OP_WRITE, 20'h0_0000, 16'h00f0, 1'b0);
        issue(PFBM_OP_READ, 20'h0_0000, 16'h0000, 1'b0);
        check("exit", got_d, pat(20'h0_0000));
    endtask : t_ident
    task automatic t_reset(input logic busy);
        int r0;
        r0 = reis;
        if (busy) begin
            issue(PFBM_OP_ERASE, 20'h4_0000, 16'h0000, 1'b0);
            wait_flag(busy_o, 1'b1, 20);
        end
        issue(PFBM_OP_RESET, 20'h0_0000, 16'h0000, 1'b0);
        wait_flag(req_ready_o, 1'b1, 6000);
        check("reissue", 16'(reis - r0), {15'h0000, busy});
        issue(PFBM_OP_READ, 20'h0_1234, 16'h0000, 1'b0);
        check("after", got_d, pat(20'h0_1234));
    endtask : t_reset
    task automatic stop_test();
        $display("Checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    initial begin
        repeat (10) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_sectors();
        t_byte();
        t_prog(PFBM_OP_PROGRAM, 20'h3_0040, 16'h1234, 4);
        t_prog(PFBM_OP_FASTPRG, 20'h3_0041, 16'hbeef, 2);
        t_prog(PFBM_OP_ERASE, 20'h5_0000, 16'h0000, 6);
        t_prog(PFBM_OP_CHIPERS, 20'h0_0000, 16'h0000, 6);
        t_ident();
        t_reset(1'b1);
        t_reset(1'b0);
        stop_test();
    end
    // Far beyond three reset recoveries plus all traffic
    initial begin
        #400000;
        err_count++;
        stop_test();
    end
endmodule : pfbm_host_tb
